/* hdl/clock_accuracy_defines.svh */
// Register offsets, field positions, reset values and counts for the
// clock accuracy monitor. Included by the monitor, the edge sampler and the bench.
`ifndef CLOCK_ACCURACY_DEFINES_SVH
`define CLOCK_ACCURACY_DEFINES_SVH

`define CAM_OFF_TARGET_CTRL 8'h00
`define CAM_OFF_REF_CTRL 8'h04
`define CAM_OFF_UPPER_BOUND 8'h08
`define CAM_OFF_LOWER_BOUND 8'h0C
`define CAM_OFF_COUNT 8'h10
`define CAM_OFF_STATUS 8'h14
`define CAM_OFF_MASK 8'h18
`define CAM_OFF_MODULE_STOP 8'h1C

`define CAM_TGT_ENABLE_BIT 0
`define CAM_SEL_LSB 1
`define CAM_SEL_MSB 3
`define CAM_REF_PIN_BIT 0
`define CAM_REF_FILTER_BIT 4

`define CAM_ST_MEAS_END 0
`define CAM_ST_FREQ_ERR 1
`define CAM_ST_OVERFLOW 2

`define CAM_CTRL_RESET 8'h00
`define CAM_STOP_RESET 1'b0
`define CAM_FILTER_LEN 3

`endif

/* hdl/clock_accuracy_monitor.sv */
// Clock accuracy monitor: counts target clock edges per reference period.
// Assumes all clock inputs are sampled levels synchronous to ref_clk_i.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "clock_accuracy_defines.svh"

// Behaviour
// R1: The target clock is picked by bits 3..1 of the target control register.
// R2: The internal reference is picked by bits 3..1 of reference control.
// R3: Software must not write select codes outside the listed encodings.
// R4: The external reference pin may be chosen as reference instead.
// R5: A module-stop bit halts all measurement logic.
// R6: Edges are counted per reference period with end, error, wrap events.
module clock_accuracy_monitor
    import clock_accuracy_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int FILTER_LEN = `CAM_FILTER_LEN
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic main_clock_i,
    input wire logic fast_internal_oscillator_clock_i,
    input wire logic slow_internal_oscillator_clock_i,
    input wire logic watchdog_oscillator_clock_i,
    input wire logic peripheral_clock_b_i,
    input wire logic external_reference_input_i,
    output logic irq_o
);
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    logic [7:0] measure_target_control;
    logic [7:0] measure_reference_control;
    logic [CNT_W-1:0] upper_bound;
    logic [CNT_W-1:0] lower_bound;
    logic [CNT_W-1:0] count_value;
    logic [CNT_W-1:0] counter;
    logic [2:0] status;
    logic [2:0] mask;
    logic module_stop;
    meas_state_t state;
    logic [2:0] target_clock_select;
    logic [2:0] reference_clock_select;
    logic measure_enable;
    logic active;
    logic capture;
    logic wrap;
    logic freq_err;
    logic [2:0] events;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic [31:0] next_rdata;

    edge_if tgt ();
    edge_if refc ();

    assign target_clock_select =
        measure_target_control[`CAM_SEL_MSB:`CAM_SEL_LSB];
    assign reference_clock_select =
        measure_reference_control[`CAM_SEL_MSB:`CAM_SEL_LSB];
    assign measure_enable = measure_target_control[`CAM_TGT_ENABLE_BIT];
    assign active = measure_enable && !module_stop;

    function automatic logic pick_clock(input logic [2:0] code,
            input logic [4:0] src);
        logic result;
        result = 1'b0;
        case (code)
            SRC_MAIN: result = src[0];
            SRC_FAST: result = src[1];
            SRC_SLOW: result = src[2];
            SRC_WDT: result = src[3];
            SRC_PERIPHERAL_CLOCK_B: result = src[4];
            default: result = 1'b0; // R3
        endcase
        return result;
    endfunction

    logic [4:0] sources;
    assign sources = {peripheral_clock_b_i, watchdog_oscillator_clock_i,
        slow_internal_oscillator_clock_i, fast_internal_oscillator_clock_i,
        main_clock_i};

    assign tgt.level = pick_clock(target_clock_select, sources); // R1
    assign tgt.filter_en = 1'b0;
    assign refc.level = measure_reference_control[`CAM_REF_PIN_BIT] ?
        external_reference_input_i : // R4
        pick_clock(reference_clock_select, sources); // R2
    assign refc.filter_en = measure_reference_control[`CAM_REF_FILTER_BIT];

    // Samplers are cleared whenever measurement is off or stopped.
    clock_edge_sampler #(.FILTER_LEN(FILTER_LEN)) u_target (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .clear_i(!active), // R5
        .port(tgt.sampler)
    );

    clock_edge_sampler #(.FILTER_LEN(FILTER_LEN)) u_reference (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .clear_i(!active),
        .port(refc.sampler)
    );

    assign capture = (state == ST_MEASURE) && refc.rise;
    assign wrap = (state == ST_MEASURE) && tgt.rise && !refc.rise &&
        (counter == CNT_MAX);
    assign freq_err = capture &&
        ((counter > upper_bound) || (counter < lower_bound));
    assign events = {wrap, freq_err, capture};

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !active) begin
            state <= ST_IDLE; // R5
            counter <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    state <= ST_WAIT_FIRST;
                    counter <= '0;
                end
                ST_WAIT_FIRST: begin
                    if (refc.rise) begin
                        state <= ST_MEASURE;
                        // A coincident target edge opens the first period.
                        counter <= {{(CNT_W-1){1'b0}}, tgt.rise}; // R6
                    end
                end
                ST_MEASURE: begin
                    if (refc.rise) begin
                        counter <= {{(CNT_W-1){1'b0}}, tgt.rise}; // R6
                    end else if (tgt.rise) begin
                        counter <= counter + CNT_W'(1); // R6
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_value <= '0;
        end else if (capture) begin
            count_value <= counter; // R6
        end
    end

    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;

    always_comb begin
        addr_ok = 1'b1;
        next_rdata = 32'h0000_0000;
        if (paddr_i == `CAM_OFF_TARGET_CTRL) begin
            next_rdata[7:0] = measure_target_control;
        end else if (paddr_i == `CAM_OFF_REF_CTRL) begin
            next_rdata[7:0] = measure_reference_control;
        end else if (paddr_i == `CAM_OFF_UPPER_BOUND) begin
            next_rdata[CNT_W-1:0] = upper_bound;
        end else if (paddr_i == `CAM_OFF_LOWER_BOUND) begin
            next_rdata[CNT_W-1:0] = lower_bound;
        end else if (paddr_i == `CAM_OFF_COUNT) begin
            next_rdata[CNT_W-1:0] = count_value;
        end else if (paddr_i == `CAM_OFF_STATUS) begin
            next_rdata[2:0] = status;
        end else if (paddr_i == `CAM_OFF_MASK) begin
            next_rdata[2:0] = mask;
        end else if (paddr_i == `CAM_OFF_MODULE_STOP) begin
            next_rdata[0] = module_stop;
        end else begin
            addr_ok = 1'b0;
        end
    end

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_o <= next_rdata;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            measure_target_control <= `CAM_CTRL_RESET;
            measure_reference_control <= `CAM_CTRL_RESET;
            upper_bound <= '0;
            lower_bound <= '0;
            mask <= 3'h0;
            module_stop <= `CAM_STOP_RESET;
        end else if (wr_en) begin
            if (paddr_i == `CAM_OFF_TARGET_CTRL) begin
                measure_target_control <= pwdata_i[7:0];
            end else if (paddr_i == `CAM_OFF_REF_CTRL) begin
                measure_reference_control <= pwdata_i[7:0];
            end else if (paddr_i == `CAM_OFF_UPPER_BOUND) begin
                upper_bound <= pwdata_i[CNT_W-1:0];
            end else if (paddr_i == `CAM_OFF_LOWER_BOUND) begin
                lower_bound <= pwdata_i[CNT_W-1:0];
            end else if (paddr_i == `CAM_OFF_MASK) begin
                mask <= pwdata_i[2:0];
            end else if (paddr_i == `CAM_OFF_MODULE_STOP) begin
                module_stop <= pwdata_i[0];
            end
        end
    end

    // A new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            status <= 3'h0;
        end else if (wr_en && paddr_i == `CAM_OFF_STATUS) begin
            status <= (status & ~pwdata_i[2:0]) | events; // R6
        end else begin
            status <= status | events; // R6
        end
    end

    assign irq_o = |(status & mask);

    logic irq_reg_write;
    assign irq_reg_write = wr_en && ((paddr_i == `CAM_OFF_STATUS) ||
        (paddr_i == `CAM_OFF_MASK));

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_period_end;
        (state == ST_MEASURE) && refc.rise && active;
    endsequence

    sequence seq_wrap;
        wrap && active;
    endsequence

    a_target_select: assert property ( // R1
        (target_clock_select == SRC_SLOW) |->
        (tgt.level == slow_internal_oscillator_clock_i))
        else $error("target mux does not follow select code");

    a_reference_select: assert property ( // R2
        !measure_reference_control[`CAM_REF_PIN_BIT] &&
        (reference_clock_select == SRC_PERIPHERAL_CLOCK_B) |->
        (refc.level == peripheral_clock_b_i))
        else $error("reference mux does not follow select code");

    a_forbidden_code: assert property ( // R3
        (target_clock_select == 3'b001) |-> !tgt.level)
        else $error("forbidden target code passes a clock");

    a_pin_reference: assert property ( // R4
        measure_reference_control[`CAM_REF_PIN_BIT] |->
        (refc.level == external_reference_input_i))
        else $error("external reference pin not routed");

    a_stop_halts: assert property ( // R5
        module_stop |=> (state == ST_IDLE) && (counter == '0))
        else $error("module stop does not halt measurement");

    a_end_flag_set: assert property ( // R6
        seq_period_end |=> status[`CAM_ST_MEAS_END] &&
        (count_value == $past(counter)))
        else $error("period end not captured or flagged");

    a_error_bounds: assert property ( // R6
        seq_period_end ##0 (counter > upper_bound) |=>
        status[`CAM_ST_FREQ_ERR])
        else $error("out of bound count not flagged");

    a_overflow_wrap: assert property ( // R6
        seq_wrap |=> (counter == '0) && status[`CAM_ST_OVERFLOW])
        else $error("counter wrap not flagged");

    a_irq_level: assert property ( // R6
        $fell(irq_o) |-> $past(irq_reg_write))
        else $error("interrupt dropped without a status or mask write");
endmodule
`default_nettype wire

/* hdl/clock_accuracy_pkg.sv */
// Types shared by the clock accuracy monitor modules.
// Assumes the defines header is compiled alongside.
package clock_accuracy_pkg;
    typedef enum logic [2:0] {
        SRC_MAIN  = 3'b000,
        SRC_FAST  = 3'b010,
        SRC_SLOW  = 3'b011,
        SRC_WDT   = 3'b100,
        SRC_PERIPHERAL_CLOCK_B = 3'b101
    } clock_code_t;

    typedef enum logic [1:0] {
        ST_IDLE       = 2'b00,
        ST_WAIT_FIRST = 2'b01,
        ST_MEASURE    = 2'b10
    } meas_state_t;
endpackage

/* hdl/clock_edge_sampler.sv */
// Edge sampler with optional digital filter for one sampled clock level.
// Assumes the level is synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "clock_accuracy_defines.svh"
module clock_edge_sampler #(
    parameter int FILTER_LEN = `CAM_FILTER_LEN
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    edge_if.sampler port
);
    localparam int RW = $clog2(FILTER_LEN) + 1;
    localparam logic [RW-1:0] RUN_FULL = RW'(FILTER_LEN - 1);

    logic last;
    logic accepted;
    logic rise;
    logic [RW-1:0] run;
    logic [RW-1:0] next_run;
    logic next_accepted;

    // The filter only lets a level through after FILTER_LEN equal samples.
    always_comb begin
        next_run = (port.level == last) ?
            ((run == RUN_FULL) ? run : run + RW'(1)) : '0;
        if (!port.filter_en || next_run == RUN_FULL) begin
            next_accepted = port.level;
        end else begin
            next_accepted = accepted;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            last <= 1'b0;
            run <= '0;
            // A cleared sampler counts as high, so a level already high
            // when measurement starts is not taken for a rising edge.
            accepted <= 1'b1;
            rise <= 1'b0;
        end else begin
            last <= port.level;
            run <= next_run;
            accepted <= next_accepted;
            rise <= next_accepted & ~accepted;
        end
    end

    assign port.rise = rise;
endmodule
`default_nettype wire

/* hdl/edge_if.sv */
// Carrier between the monitor core and one edge sampler.
// Assumes both ends share ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
interface edge_if;
    logic level;
    logic filter_en;
    logic rise;
    modport owner (output level, output filter_en, input rise);
    modport sampler (input level, input filter_en, output rise);
endinterface
`default_nettype wire

/* tb/clock_accuracy_monitor_tb.sv */
// Self-checking bench for the clock accuracy monitor.
// Assumes the defines header and the package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "clock_accuracy_defines.svh"
module clock_accuracy_monitor_tb
    import clock_accuracy_pkg::*;
;
    typedef struct {
        logic [2:0] tgt, rs;
        logic pin, filt;
        logic [7:0] half, cnt, lo, hi;
        logic [2:0] st;
    } row_t;
    // Codes stay inside the listed encodings.
    row_t rows [12] = '{
        '{SRC_MAIN, SRC_MAIN, 1'b1, 1'b0, 8'h3C, 8'h1E, 8'h1E, 8'h1E, 3'h1},
        '{SRC_FAST, SRC_MAIN, 1'b1, 1'b0, 8'h3C, 8'h14, 8'h14, 8'h14, 3'h1},
        '{SRC_SLOW, SRC_MAIN, 1'b1, 1'b1, 8'h3C, 8'h0F, 8'h0F, 8'h0F, 3'h1},
        '{SRC_WDT, SRC_MAIN, 1'b1, 1'b0, 8'h3C, 8'h0C, 8'h0C, 8'h0C, 3'h1},
        '{SRC_PERIPHERAL_CLOCK_B, SRC_MAIN, 1'b1, 1'b0, 8'h3C, 8'h0A, 8'h0B, 8'h14, 3'h3},
        '{SRC_MAIN, SRC_MAIN, 1'b0, 1'b0, 8'h3C, 8'h01, 8'h01, 8'h01, 3'h1},
        '{SRC_MAIN, SRC_SLOW, 1'b0, 1'b0, 8'h3C, 8'h02, 8'h02, 8'h02, 3'h1},
        '{SRC_MAIN, SRC_PERIPHERAL_CLOCK_B, 1'b0, 1'b0, 8'h3C, 8'h03, 8'h00, 8'h02, 3'h3},
        '{SRC_FAST, SRC_PERIPHERAL_CLOCK_B, 1'b0, 1'b0, 8'h3C, 8'h02, 8'h02, 8'h02, 3'h1},
        '{SRC_WDT, SRC_WDT, 1'b0, 1'b0, 8'h3C, 8'h01, 8'h01, 8'h01, 3'h1},
        '{SRC_FAST, SRC_FAST, 1'b0, 1'b0, 8'h3C, 8'h01, 8'h01, 8'h01, 3'h1},
        '{SRC_MAIN, SRC_MAIN, 1'b1, 1'b0, 8'h78, 8'h1C, 8'h00, 8'h1F, 3'h5}
    };
    logic ref_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, irq;
    logic mclk, fclk, sclk, wclk, pclk, ext;
    logic [7:0] paddr, ext_half;
    logic [31:0] pwdata, prdata, rdv;
    logic erv;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;

    clock_sources_model i_src (.clk_i(ref_clk_i), .rst_i(rst_i),
        .ext_half_i(ext_half), .main_o(mclk), .fast_o(fclk), .slow_o(sclk),
        .wdt_o(wclk), .peripheral_clock_b_o(pclk), .ext_o(ext));

    // A 5-bit counter lets a long pin period reach the wrap quickly.
    clock_accuracy_monitor #(.CNT_W(5)) i_dut (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .main_clock_i(mclk),
        .fast_internal_oscillator_clock_i(fclk),
        .slow_internal_oscillator_clock_i(sclk),
        .watchdog_oscillator_clock_i(wclk), .peripheral_clock_b_i(pclk),
        .external_reference_input_i(ext), .irq_o(irq));

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdv, erv);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rdv, erv);
        chk(rdv, exp);
    endtask

    task automatic wait_end();
        int k;
        k = 0;
        rdv = 32'h0000_0000;
        while (rdv[0] !== 1'b1 && k < 200) begin
            apb(1'b0, `CAM_OFF_STATUS, 32'h0000_0000, rdv, erv);
            k++;
        end
        chk(32'(rdv[0]), 32'h0000_0001);
    endtask

    task automatic measure(input row_t x);
        ext_half <= x.half;
        wr(`CAM_OFF_TARGET_CTRL, 32'h0000_0000);
        wr(`CAM_OFF_LOWER_BOUND, 32'(x.lo));
        wr(`CAM_OFF_UPPER_BOUND, 32'(x.hi));
        wr(`CAM_OFF_REF_CTRL, 32'({x.filt, x.rs, x.pin}));
        wr(`CAM_OFF_STATUS, 32'h0000_0007);
        wr(`CAM_OFF_TARGET_CTRL, 32'({x.tgt, 1'b1}));
        wait_end();
        rd_chk(`CAM_OFF_STATUS, 32'(x.st));
        rd_chk(`CAM_OFF_COUNT, 32'(x.cnt));
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = !ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        rst_i = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        ext_half = 8'h3C;
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            measure(rows[i]);
        end
        wr(`CAM_OFF_MASK, 32'h0000_0001);
        @(posedge ref_clk_i);
        chk(32'(irq), 32'h0000_0001);
        wr(`CAM_OFF_MASK, 32'h0000_0000);
        @(posedge ref_clk_i);
        chk(32'(irq), 32'h0000_0000);
        wr(`CAM_OFF_MASK, 32'h0000_0004);
        @(posedge ref_clk_i);
        chk(32'(irq), 32'h0000_0001);
        wr(`CAM_OFF_TARGET_CTRL, 32'h0000_0000);
        wr(`CAM_OFF_STATUS, 32'h0000_0007);
        @(posedge ref_clk_i);
        chk(32'(irq), 32'h0000_0000);
        wr(`CAM_OFF_MODULE_STOP, 32'h0000_0001);
        wr(`CAM_OFF_TARGET_CTRL, 32'h0000_0001);
        repeat (600) @(posedge ref_clk_i);
        rd_chk(`CAM_OFF_STATUS, 32'h0000_0000);
        wr(`CAM_OFF_MODULE_STOP, 32'h0000_0000);
        wait_end();
        apb(1'b0, 8'h20, 32'h0000_0000, rdv, erv);
        chk(rdv, 32'h0000_0000);
        chk(32'(erv), 32'h0000_0001);
        rst_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd_chk(`CAM_OFF_TARGET_CTRL, 32'h0000_0000);
        rd_chk(`CAM_OFF_REF_CTRL, 32'h0000_0000);
        rd_chk(`CAM_OFF_STATUS, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        conclude();
    end
endmodule
`default_nettype wire

/* tb/clock_sources_model.sv */
// Partner model: free-running on-chip clocks and the reference pin.
// Assumes every output is a level launched on the rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module clock_sources_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] ext_half_i,
    output logic main_o,
    output logic fast_o,
    output logic slow_o,
    output logic wdt_o,
    output logic peripheral_clock_b_o,
    output logic ext_o
);
    logic [31:0] cnt;
    logic [7:0] ecnt;
    always_ff @(posedge clk_i) begin
        cnt <= rst_i ? 32'h0000_0000 : cnt + 32'h0000_0001;
    end
    // The pin period is set by the bench so long periods can force a wrap.
    always_ff @(posedge clk_i) begin
        if (rst_i || ecnt + 8'h01 >= ext_half_i) begin
            ecnt <= 8'h00;
        end else begin
            ecnt <= ecnt + 8'h01;
        end
        if (rst_i) begin
            ext_o <= 1'b0;
        end else if (ecnt + 8'h01 >= ext_half_i) begin
            ext_o <= !ext_o;
        end
    end
    assign main_o = (cnt % 32'h0000_0004) >= 32'h0000_0002;
    assign fast_o = (cnt % 32'h0000_0006) >= 32'h0000_0003;
    assign slow_o = (cnt % 32'h0000_0008) >= 32'h0000_0004;
    assign wdt_o = (cnt % 32'h0000_000A) >= 32'h0000_0005;
    assign peripheral_clock_b_o = (cnt % 32'h0000_000C) >= 32'h0000_0006;
endmodule
`default_nettype wire
